// [verilog/tccc_timer_ch12.v]
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/10ps
// Function
// - channel 1 bit 6 enables its interrupt request, resets to one.
// - channel 2 bit 6 gates its interrupt request, resets to one.
// - bits 5:3 choose output action on match with own value.
// - code 000 sets, 001 clears, 010 toggles output on match.
// - 011 sets on up match, clears at zero or down match.
// - 100 clears on up match, sets at zero or down match.
// - channel 1 code 101 clears at channel 0 value, sets at own.
// - channel 1 code 110 sets at channel 0 value, clears at own.
// - channel 2 codes 101 and 110 behave likewise, also using channel 0 value.
// - channel 1 bit 2 selects capture (0) or compare (1).
// - channel 2 bit 2 selects capture (0) or compare (1).
// - bits 1:0 choose none, rising, falling or both capture edges.
// - channel 1 value held as readable high and low bytes, reset zero.
// - channel 2 value held as readable high and low bytes, reset zero.
// - modulo and up/down counter modes decide compare direction.
// - hardware sets channel flag; write zero clears, one ignored.
`include "tccc_regs.vh"

module tccc_timer_ch12 (
	input wire core_clk_i, // system clock
	input wire rstn_i, // synchronous reset, active low
	input wire [7:0] avs_address_i, // byte address
	input wire avs_read_i, // read request
	input wire avs_write_i, // write request
	input wire [31:0] avs_writedata_i, // write data, low byte used
	output reg [31:0] avs_readdata_o, // read data
	output wire avs_waitrequest_o, // stall
	input wire tick_i, // counter advanced this cycle
	input wire [15:0] count_i, // shared counter value
	input wire [1:0] count_mode_i, // shared counter mode
	input wire count_down_i, // counter counting down
	input wire [15:0] chan0_match_value_i, // channel 0 value
	input wire [1:0] capture_in_i, // capture inputs, bit per channel
	output wire [1:0] compare_out_o, // compare outputs
	output wire [1:0] chan_event_flag_o, // event flags
	output wire irq_o // level interrupt
);

//------------------------------------------------------------
// bus handshake
//------------------------------------------------------------
// one wait cycle per access so read data comes from a flop
reg ack;
wire req = (avs_read_i | avs_write_i) & ~ack;
assign avs_waitrequest_o = req;
wire wr_done = avs_write_i & ack;
wire [7:0] wdata = avs_writedata_i[7:0];

always @(posedge core_clk_i) begin
	if (!rstn_i) begin
		ack <= 1'b0;
	end else begin
		ack <= req;
	end
end

// irq mask register, two bits
reg [1:0] irq_mask;
reg [1:0] event_flag;
reg [1:0] cap_d;

//------------------------------------------------------------
// per-channel logic
//------------------------------------------------------------
wire [7:0] ctrl_rd [0:1];
wire [15:0] value_rd [0:1];
wire [1:0] event_pulse;
reg [15:0] count_d;

genvar ch;
generate
for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
	reg [7:0] ctrl;
	reg [7:0] val_lo;
	reg [7:0] val_hi;
	reg out_q;
	reg next_out;
	wire [7:0] a_lo = ch ? `TCCC_CH2_LOW : `TCCC_CH1_LOW;
	wire [7:0] a_hi = ch ? `TCCC_CH2_HIGH : `TCCC_CH1_HIGH;
	wire [7:0] a_ct = ch ? `TCCC_CH2_CTRL : `TCCC_CH1_CTRL;
	wire [2:0] act = ctrl[`TCCC_ACT_HI:`TCCC_ACT_LO];
	wire [1:0] edge_sel = ctrl[`TCCC_CAP_HI:`TCCC_CAP_LO];
	wire cmp_mode = ctrl[`TCCC_MODE_BIT];
	wire [15:0] own = {val_hi, val_lo};
	wire rise = capture_in_i[ch] & ~cap_d[ch];
	wire fall = ~capture_in_i[ch] & cap_d[ch];
	wire cap_hit = ~cmp_mode & (((edge_sel == `TCCC_CAP_RISE) & rise) |
		((edge_sel == `TCCC_CAP_FALL) & fall) |
		((edge_sel == `TCCC_CAP_BOTH) & (rise | fall)));
	// match is judged once per tick on the new counter value
	wire own_m = cmp_mode & tick_i & (count_i == own) & (count_i != count_d);
	wire ch0_m = cmp_mode & tick_i & (count_i == chan0_match_value_i) & (count_i != count_d);
	wire zero_m = cmp_mode & tick_i & (count_i == `TCCC_ZERO16) & (count_i != count_d);
	wire updn = (count_mode_i == `TCCC_MODE_UPDOWN);
	assign event_pulse[ch] = own_m | cap_hit;
	assign ctrl_rd[ch] = ctrl;
	assign value_rd[ch] = own;
	assign compare_out_o[ch] = out_q;

	// output action on compare
	always @* begin
		next_out = out_q;
		case (act)
		`TCCC_ACT_SET: if (own_m) next_out = 1'b1;
		`TCCC_ACT_CLR: if (own_m) next_out = 1'b0;
		`TCCC_ACT_TOG: if (own_m) next_out = ~out_q;
		`TCCC_ACT_SETUP: begin
			if (updn) begin
				if (own_m) next_out = ~count_down_i;
			end else if (own_m) begin
				next_out = 1'b1;
			end else if (zero_m) begin
				next_out = 1'b0;
			end
		end
		`TCCC_ACT_CLRUP: begin
			if (updn) begin
				if (own_m) next_out = count_down_i;
			end else if (own_m) begin
				next_out = 1'b0;
			end else if (zero_m) begin
				next_out = 1'b1;
			end
		end
		`TCCC_ACT_C0CLR: begin
			if (own_m) next_out = 1'b1;
			else if (ch0_m) next_out = 1'b0;
		end
		`TCCC_ACT_C0SET: begin
			if (own_m) next_out = 1'b0;
			else if (ch0_m) next_out = 1'b1;
		end
		default: next_out = out_q;
		endcase
	end

	// registers; capture wins over a same-cycle bus write
	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			ctrl <= `TCCC_CTRL_RESET;
			val_lo <= `TCCC_BYTE_RESET;
			val_hi <= `TCCC_BYTE_RESET;
			out_q <= 1'b0;
		end else begin
			out_q <= next_out;
			if (wr_done && avs_address_i == a_ct) ctrl <= wdata;
			if (cap_hit) begin
				val_lo <= count_i[7:0];
				val_hi <= count_i[15:8];
			end else begin
				if (wr_done && avs_address_i == a_lo) val_lo <= wdata;
				if (wr_done && avs_address_i == a_hi) val_hi <= wdata;
			end
		end
	end
end
endgenerate

//------------------------------------------------------------
// flags, mask and interrupt
//------------------------------------------------------------
// set beats a clearing write in the same cycle
wire clr_wr = wr_done && (avs_address_i == `TCCC_STATUS);
wire [1:0] im = {ctrl_rd[1][`TCCC_IM_BIT], ctrl_rd[0][`TCCC_IM_BIT]};

always @(posedge core_clk_i) begin
	if (!rstn_i) begin
		event_flag <= `TCCC_FLAG_RESET;
		irq_mask <= `TCCC_MASK_RESET;
		cap_d <= 2'h0;
		count_d <= `TCCC_ZERO16;
	end else begin
		cap_d <= capture_in_i;
		if (tick_i) count_d <= count_i;
		// writing one to a flag is ignored, zero clears
		event_flag <= event_pulse | (clr_wr ? (event_flag & wdata[1:0]) : event_flag);
		if (wr_done && avs_address_i == `TCCC_IRQ_MASK) irq_mask <= wdata[1:0];
	end
end

assign chan_event_flag_o = event_flag;
// request only while channel mask bit and its irq_mask bit both set
assign irq_o = |(event_flag & im & irq_mask);

//------------------------------------------------------------
// read mux
//------------------------------------------------------------
always @(posedge core_clk_i) begin
	if (!rstn_i) begin
		avs_readdata_o <= 32'h0;
	end else if (avs_read_i && req) begin
		case (avs_address_i)
		`TCCC_CH1_LOW: avs_readdata_o <= {24'h0, value_rd[0][7:0]};
		`TCCC_CH1_HIGH: avs_readdata_o <= {24'h0, value_rd[0][15:8]};
		`TCCC_CH2_LOW: avs_readdata_o <= {24'h0, value_rd[1][7:0]};
		`TCCC_CH2_HIGH: avs_readdata_o <= {24'h0, value_rd[1][15:8]};
		`TCCC_CH1_CTRL: avs_readdata_o <= {24'h0, ctrl_rd[0]};
		`TCCC_CH2_CTRL: avs_readdata_o <= {24'h0, ctrl_rd[1]};
		`TCCC_STATUS: avs_readdata_o <= {30'h0, event_flag};
		`TCCC_IRQ_MASK: avs_readdata_o <= {30'h0, irq_mask};
		default: avs_readdata_o <= 32'h0;
		endcase
	end
end

endmodule // tccc_timer_ch12

// [common/tccc_regs.vh]
`ifndef TCCC_REGS_VH
`define TCCC_REGS_VH
// register byte addresses
`define TCCC_ADDR_W 8
`define TCCC_CH1_LOW 8'hdc
`define TCCC_CH1_HIGH 8'hdd
`define TCCC_CH2_LOW 8'hde
`define TCCC_CH2_HIGH 8'hdf
`define TCCC_CH1_CTRL 8'he6
`define TCCC_CH2_CTRL 8'he7
`define TCCC_STATUS 8'hf0
`define TCCC_IRQ_MASK 8'hf4
// control fields
`define TCCC_RSVD_BIT 7
`define TCCC_IM_BIT 6
`define TCCC_ACT_HI 5
`define TCCC_ACT_LO 3
`define TCCC_MODE_BIT 2
`define TCCC_CAP_HI 1
`define TCCC_CAP_LO 0
`define TCCC_CTRL_RESET 8'h40
`define TCCC_BYTE_RESET 8'h00
`define TCCC_MASK_RESET 2'h3
`define TCCC_FLAG_RESET 2'h0
// output action codes
`define TCCC_ACT_SET 3'h0
`define TCCC_ACT_CLR 3'h1
`define TCCC_ACT_TOG 3'h2
`define TCCC_ACT_SETUP 3'h3
`define TCCC_ACT_CLRUP 3'h4
`define TCCC_ACT_C0CLR 3'h5
`define TCCC_ACT_C0SET 3'h6
// capture edge codes
`define TCCC_CAP_RISE 2'h1
`define TCCC_CAP_FALL 2'h2
`define TCCC_CAP_BOTH 2'h3
// counter modes
`define TCCC_MODE_UPDOWN 2'h3
`define TCCC_ZERO16 16'h0000
`endif

// [verification/tccc_pin_model.sv]
`timescale 1ns/10ps
module tccc_pin_model (
	input wire clk_i, // clock
	input wire [1:0] level_i, // wanted pin levels
	output reg [1:0] pin_o // capture pins
);
	// levels move only on the clock so edges never race the sampler
	always @(posedge clk_i) begin
		pin_o <= level_i;
	end
endmodule // tccc_pin_model

// [verification/tccc_timer_ch12_assertions.sv]
`timescale 1ns/10ps
`include "tccc_regs.vh"
module tccc_chk (
	input wire core_clk_i, // clock
	input wire rstn_i, // reset
	input wire [7:0] avs_address_i, // address
	input wire avs_read_i, // read
	input wire avs_write_i, // write
	input wire [31:0] avs_writedata_i, // data in
	input wire [31:0] avs_readdata_o, // data out
	input wire avs_waitrequest_o, // stall
	input wire tick_i, // tick
	input wire [1:0] compare_out_o, // outputs
	input wire [1:0] chan_event_flag_o, // flags
	input wire irq_o // irq
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	// past-reset guards keep a mid-run reset from looking like a clear
	wire req = avs_read_i | avs_write_i;
	wire stw = avs_write_i & !avs_waitrequest_o & (avs_address_i == `TCCC_STATUS);
	wire hole = !(avs_address_i inside {[8'hdc:8'hdf], 8'he6, 8'he7, 8'hf0, 8'hf4});
	a_one_wait: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("stall past one cycle");
	a_idle_nowait: assert property (!req |-> !avs_waitrequest_o)
		else $error("stall while idle");
	a_read_upper: assert property (avs_readdata_o[31:8] == 24'h0)
		else $error("upper read bits set");
	a_hole_zero: assert property (avs_read_i && !avs_waitrequest_o && hole |-> avs_readdata_o == 0)
		else $error("unmapped read not zero");
	a_irq_flag: assert property (irq_o |-> chan_event_flag_o != 2'h0)
		else $error("irq without flag");
	a_flag_sticky: assert property ($past(rstn_i) && $fell(chan_event_flag_o[0]) |-> $past(stw))
		else $error("flag dropped without write");
	a_one_kept: assert property (stw && avs_writedata_i[0] && chan_event_flag_o[0] |=> chan_event_flag_o[0])
		else $error("flag cleared by one");
	a_out_tick: assert property ($past(rstn_i) && !$past(tick_i) && !$past(tick_i, 2) |-> $stable(compare_out_o))
		else $error("output moved without tick");
endmodule // tccc_chk
bind tccc_timer_ch12 tccc_chk u_chk (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .tick_i(tick_i), .compare_out_o(compare_out_o),
	.chan_event_flag_o(chan_event_flag_o), .irq_o(irq_o));

// [verification/tccc_timer_ch12_tb_top.sv]
`timescale 1ns/10ps
module tccc_timer_ch12_tb_top;
	logic clk = 0, rstn = 0, rd = 0, wr = 0, tick = 0, down = 0, irq, stall;
	logic [7:0] ad = 0, q;
	logic [31:0] wd = 0, rdata;
	logic [15:0] cnt = 0, c0 = 16'h0009;
	logic [1:0] mode = 2'h2, lvl = 0, pin, cout, flg;
	// nibbles: channel, action code, count, {updown, down, expected}
	logic [15:0] tbl [0:14] = '{16'h0051, 16'h0150, 16'h0251, 16'h0250, 16'h0351, 16'h0300,
		16'h0454, 16'h0457, 16'h0590, 16'h0551, 16'h0691, 16'h0650, 16'h0750, 16'h1551, 16'h1650};
	integer miscompares = 0, comparisons = 0, i;
	// clock
	initial begin
		forever #12.5 clk = ~clk;
	end
	tccc_pin_model pm (.clk_i(clk), .level_i(lvl), .pin_o(pin));
	tccc_timer_ch12 dut (.core_clk_i(clk), .rstn_i(rstn), .avs_address_i(ad), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(stall),
		.tick_i(tick), .count_i(cnt), .count_mode_i(mode), .count_down_i(down),
		.chan0_match_value_i(c0), .capture_in_i(pin), .compare_out_o(cout),
		.chan_event_flag_o(flg), .irq_o(irq));
	task chk(input logic [15:0] g, e);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("mismatch at %0t got %h expected %h", $time, g, e);
			end
		end
	endtask
	// request holds until the rising edge that samples stall low; data taken there
	task bus(input logic w, input logic [7:0] a, d);
		integer n;
		begin
			@(posedge clk);
			rd <= !w;
			wr <= w;
			ad <= a;
			wd <= {24'h0, d};
			n = 0;
			@(posedge clk);
			while (stall !== 1'b0 && n < 50) begin
				@(posedge clk);
				n = n + 1;
			end
			if (n == 50) miscompares = miscompares + 1;
			q = rdata[7:0];
			rd <= 0;
			wr <= 0;
		end
	endtask
	task rdchk(input logic [7:0] a, e);
		begin
			bus(0, a, 0);
			chk(q, e);
		end
	endtask
	task tk(input logic [15:0] v);
		begin
			@(posedge clk);
			tick <= 1;
			cnt <= v;
			@(posedge clk);
			tick <= 0;
		end
	endtask
	task step(input logic ch, input logic [2:0] code, input logic [3:0] v, input logic [1:0] ud, input logic e);
		begin
			bus(1, 8'he6 + ch, {2'b01, code, 3'b100});
			mode <= ud[1] ? 2'h3 : 2'h2;
			down <= ud[0];
			tk(16'h0007);
			tk({12'h0, v});
			repeat (3) @(negedge clk);
			chk(cout[ch], e);
		end
	endtask
	task t_rst;
		begin
			chk({cout, flg, irq}, 0);
			for (i = 0; i < 4; i = i + 1) rdchk(8'hdc + i, 8'h00);
			rdchk(8'he6, 8'h40);
			rdchk(8'he7, 8'h40);
			rdchk(8'hf4, 8'h03);
			bus(1, 8'h10, 8'hff);
			rdchk(8'h10, 8'h00);
			bus(1, 8'hdf, 8'h5a);
			rdchk(8'hdf, 8'h5a);
		end
	endtask
	task t_act;
		begin
			bus(1, 8'hdc, 8'h05);
			bus(1, 8'hde, 8'h05);
			bus(1, 8'hdf, 8'h00);
			for (i = 0; i < 15; i = i + 1) step(tbl[i][12], tbl[i][10:8], tbl[i][7:4], tbl[i][2:1], tbl[i][0]);
		end
	endtask
	task t_irq;
		begin
			bus(1, 8'hf0, 8'hff);
			chk({flg, irq}, 3'h7);
			bus(1, 8'hf0, 8'h00);
			repeat (2) @(negedge clk);
			chk({flg, irq}, 0);
			bus(1, 8'hf4, 8'h00);
			step(0, 0, 5, 0, 1);
			chk({flg[0], irq}, 2'h2);
			bus(1, 8'hf4, 8'h01);
			repeat (2) @(negedge clk);
			chk(irq, 1);
			bus(1, 8'he6, 8'h04);
			repeat (2) @(negedge clk);
			chk(irq, 0);
		end
	endtask
	// code, level, hit nibbles per capture step
	task t_cap;
		logic [27:0] cp;
		logic [15:0] e;
		logic [3:0] c;
		begin
			cp = 28'h74a9fd2;
			e = 16'h0005;
			bus(1, 8'hf0, 8'h00);
			for (i = 0; i < 7; i = i + 1) begin
				c = cp[4 * (6 - i) +: 4];
				bus(1, 8'he6, {6'h10, c[3:2]});
				cnt <= 16'ha000 + i;
				lvl <= {1'b0, c[1]};
				repeat (4) @(negedge clk);
				if (c[0]) e = 16'ha000 + i;
				rdchk(8'hdc, e[7:0]);
				rdchk(8'hdd, e[15:8]);
			end
			chk(flg[0], 1);
		end
	endtask
	task results;
		begin
			$display("comparisons %0d miscompares %0d", comparisons, miscompares);
			if (miscompares == 0 && comparisons > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1;
		t_rst;
		t_act;
		t_irq;
		t_cap;
		results;
	end
	// watchdog, about thirteen times the expected run
	initial begin
		#100000;
		miscompares = miscompares + 1;
		results;
	end
endmodule // tccc_timer_ch12_tb_top
